// ==== include/mpoc_defines.vh ====
// Purpose: Constants for the meter pulse output control block.
// Assumes: 40 MHz core clock, 32-bit Avalon-MM register bus.
// Notes:   Times are in microseconds; cycle counts derive from the clock rate.
`ifndef MPOC_DEFINES_VH
`define MPOC_DEFINES_VH

// ****************************************
// Clock and pulse widths
// ****************************************
`define MPOC_CLK_KHZ        40000
`define MPOC_W73_US         5000
`define MPOC_W83_US         22000
`define MPOC_W80_US         3900
`define MPOC_W94_US         10000
`define MPOC_W95_US         32000
`define MPOC_W96_US         100000
// The clock is taken as a whole number of MHz, so the product stays inside 32 bits.
`define MPOC_US2CYC(us)     ((us) * (`MPOC_CLK_KHZ / 1000))

// ****************************************
// Output function codes
// ****************************************
`define MPOC_FC_DIV4_5      8'h49
`define MPOC_FC_BOTH_1      8'h50
`define MPOC_FC_C_1         8'h52
`define MPOC_FC_DIV4_22     8'h53
`define MPOC_FC_CNT_10      8'h5E
`define MPOC_FC_CNT_32      8'h5F
`define MPOC_FC_CNT_100     8'h60
`define MPOC_FC_CMD         8'h63
`define MPOC_FC_RESET       8'h5F

// ****************************************
// Register offsets (word index, taken from byte address bits addr[3:2])
// ****************************************
`define MPOC_REG_FUNC       2'h0
`define MPOC_REG_CMD        2'h1
`define MPOC_REG_STAT       2'h2
`define MPOC_REG_PEND       2'h3

// ****************************************
// Count-mode sources and divide-by-four terminal count
// ****************************************
`define MPOC_SRC_HEAT       2'h0
`define MPOC_SRC_COOL       2'h1
`define MPOC_SRC_VOL        2'h2
`define MPOC_DIV_FACTOR     2'h3

`endif

// ==== hw/mpoc_pulse_gen.v ====
// Purpose: One output channel: pending counter and pulse timer.
// Assumes: Events arrive as single-cycle pulses on the core clock.
// Notes:   Pulses are separated by one pulse width of open state.
`timescale 1ns/1ps
`include "mpoc_defines.vh"

module mpoc_pulse_gen #(
	parameter CW = 16,
	parameter TW = 22
) (
	// Clock and reset.
	input  wire          core_clk_i,
	input  wire          rst_i,
	// Event input and release.
	input  wire          inc_i,
	input  wire          release_i,
	input  wire          clear_i,
	input  wire [TW-1:0] width_i,
	// Output state.
	output wire          active_o,
	output wire [CW-1:0] pend_o
);
	reg [CW-1:0] pend_r;
	reg [CW-1:0] ready_r;
	reg [TW-1:0] tmr_r;
	reg          on_r;
	reg          gap_r;
	wire         start = (ready_r != {CW{1'b0}}) && !on_r && !gap_r;
	wire         done  = (tmr_r == {TW{1'b0}});

	// Pending events move to the ready count on release, so none are lost.
	always @(posedge core_clk_i) begin
		if (rst_i || clear_i) begin
			pend_r  <= {CW{1'b0}};
			ready_r <= {CW{1'b0}};
		end else begin
			if (release_i) begin
				pend_r  <= inc_i ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}};
				ready_r <= ready_r + pend_r - (start ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}});
			end else begin
				pend_r  <= pend_r + (inc_i ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}});
				ready_r <= ready_r - (start ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}});
			end
		end
	end

	// Pulse then equal gap, open state at rest.
	always @(posedge core_clk_i) begin
		if (rst_i || clear_i) begin
			on_r  <= 1'b0;
			gap_r <= 1'b0;
			tmr_r <= {TW{1'b0}};
		end else if (start) begin
			on_r  <= 1'b1;
			tmr_r <= width_i - {{(TW-1){1'b0}}, 1'b1};
		end else if (on_r || gap_r) begin
			if (done) begin
				gap_r <= on_r;
				on_r  <= 1'b0;
				tmr_r <= on_r ? width_i - {{(TW-1){1'b0}}, 1'b1} : {TW{1'b0}};
			end else begin
				tmr_r <= tmr_r - {{(TW-1){1'b0}}, 1'b1};
			end
		end
	end

	assign active_o = on_r;
	assign pend_o   = ready_r + pend_r;
endmodule // mpoc_pulse_gen

// ==== hw/mpoc_top.v ====
// Purpose: Pulse output control for outputs C and D in slots one and two.
// Assumes: Flow pulses arrive on pins; register increments and integration
//          ticks come from core logic on the same clock.
// Notes:   Registers on Avalon-MM; commanded state restored from NVM at start.
`timescale 1ns/1ps
`include "mpoc_defines.vh"

// Summary of operation
// - Code 73: C pulses per four primary, 5 ms.
// - Code 83: C divides primary by four, 22 ms.
// - Code 80: C repeats primary, D secondary, 3.9ms.
// - Code 82: C repeats primary, 3.9 ms.
// - Count mode widths 10, 32, 100 ms by code.
// - Function code resets to 95.
// - Code 99: outputs follow ON/OFF commands only.
// - Both slots of a pair driven identically.
// - Meter type fixes count-mode output sources.
// - Source selection is fixed, not reconfigurable.
// - Each count-mode pulse is one least-digit unit.
// - Code 119: energy per kWh, volume per 0.01 m3; the code only shows the resolution code in the status register.
// - Count pulses batch per integration, fixed rate.
// - Commanded pair states readable in registers.
// - Command changes saved to NVM, restored at reset.
// - Slot one and two outputs C1/C2, D1/D2.
module mpoc_top #(
	parameter        CW        = 16,
	parameter [3:0]  METER_TYPE = 4'h1
) (
	// Clock and reset.
	input  wire        core_clk_i,
	input  wire        rst_i,
	// Avalon-MM slave.
	input  wire [3:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	// Flow sensor pins.
	input  wire        primary_flow_volume_i,
	input  wire        secondary_flow_volume_i,
	// Register increment events, one per least displayed digit.
	input  wire        heat_energy_total_inc_i,
	input  wire        cooling_energy_total_inc_i,
	input  wire        volume_pulse_channel_inc_i,
	input  wire        integration_tick_i,
	// Display resolution code, informational.
	input  wire [9:0]  display_resolution_code_i,
	// Nonvolatile command state.
	input  wire [1:0]  nvm_cmd_state_i,
	output reg         nvm_save_o,
	output reg  [1:0]  nvm_cmd_state_o,
	// Pulse outputs per slot, output enable closes the opto output.
	output wire        out_c1_o,
	output wire        out_c2_o,
	output wire        out_d1_o,
	output wire        out_d2_o
);
	localparam TW = 22;
	// Cycle counts are worked out as integers, then cut to the timer width.
	localparam integer N73 = `MPOC_US2CYC(`MPOC_W73_US);
	localparam integer N83 = `MPOC_US2CYC(`MPOC_W83_US);
	localparam integer N80 = `MPOC_US2CYC(`MPOC_W80_US);
	localparam integer N94 = `MPOC_US2CYC(`MPOC_W94_US);
	localparam integer N95 = `MPOC_US2CYC(`MPOC_W95_US);
	localparam integer N96 = `MPOC_US2CYC(`MPOC_W96_US);
	localparam [TW-1:0] CYC73  = N73[TW-1:0];
	localparam [TW-1:0] CYC83  = N83[TW-1:0];
	localparam [TW-1:0] CYC80  = N80[TW-1:0];
	localparam [TW-1:0] CYC94  = N94[TW-1:0];
	localparam [TW-1:0] CYC95  = N95[TW-1:0];
	localparam [TW-1:0] CYC96  = N96[TW-1:0];

	// ****************************************
	// Registers and bus slave
	// ****************************************
	reg  [7:0]  func_r;
	reg  [1:0]  cmd_r;
	reg         ack_r;
	reg         loaded_r;
	wire        req = (avs_read_i || avs_write_i) && !ack_r;
	wire [1:0]  widx = avs_address_i[3:2];
	wire        wr_func = avs_write_i && !ack_r && widx == `MPOC_REG_FUNC && avs_byteenable_i[0];
	wire        wr_cmd  = avs_write_i && !ack_r && widx == `MPOC_REG_CMD && avs_byteenable_i[0];
	wire [CW-1:0] pend_c;
	wire [CW-1:0] pend_d;
	wire        act_c;
	wire        act_d;

	// One wait state per access; answer in the second cycle.
	assign avs_waitrequest_o = req;

	// Function code register and its reset value.
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			func_r <= `MPOC_FC_RESET;
			ack_r  <= 1'b0;
		end else begin
			ack_r <= req;
			if (wr_func) begin
				func_r <= avs_writedata_i[7:0];
			end
		end
	end

	// Commanded pair states; restored once after reset, saved on change.
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			cmd_r           <= 2'h0;
			loaded_r        <= 1'b0;
			nvm_save_o      <= 1'b0;
			nvm_cmd_state_o <= 2'h0;
		end else begin
			loaded_r   <= 1'b1;
			nvm_save_o <= 1'b0;
			if (!loaded_r) begin
				cmd_r <= nvm_cmd_state_i;
			end else if (wr_cmd && avs_writedata_i[1:0] != cmd_r) begin
				cmd_r           <= avs_writedata_i[1:0];
				nvm_save_o      <= 1'b1;
				nvm_cmd_state_o <= avs_writedata_i[1:0];
			end
		end
	end

	// Read data: function, command, status, pending count.
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0;
		end else if (avs_read_i && !ack_r) begin
			case (widx)
				`MPOC_REG_FUNC: avs_readdata_o <= {24'h0, func_r};
				`MPOC_REG_CMD:  avs_readdata_o <= {30'h0, cmd_r};
				// Status shows the resolution code above the two output states.
				`MPOC_REG_STAT: avs_readdata_o <= {20'h0, display_resolution_code_i,
					out_d1_o, out_c1_o};
				`MPOC_REG_PEND: avs_readdata_o <= {pend_d, pend_c};
				default:        avs_readdata_o <= 32'h0;
			endcase
		end
	end

	// ****************************************
	// Flow pin synchronisers and edge detect
	// ****************************************
	reg  [2:0]  p_sync_r;
	reg  [2:0]  s_sync_r;
	reg         p_lvl_r;
	reg         s_lvl_r;
	wire        p_rise = p_sync_r[1] && p_sync_r[2] && !p_lvl_r;
	wire        s_rise = s_sync_r[1] && s_sync_r[2] && !s_lvl_r;

	// Three stages; a level counts once stages two and three agree.
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			p_sync_r <= 3'h0;
			s_sync_r <= 3'h0;
			p_lvl_r  <= 1'b0;
			s_lvl_r  <= 1'b0;
		end else begin
			p_sync_r <= {p_sync_r[1:0], primary_flow_volume_i};
			s_sync_r <= {s_sync_r[1:0], secondary_flow_volume_i};
			if (p_sync_r[1] == p_sync_r[2]) begin
				p_lvl_r <= p_sync_r[2];
			end
			if (s_sync_r[1] == s_sync_r[2]) begin
				s_lvl_r <= s_sync_r[2];
			end
		end
	end

	// ****************************************
	// Mode decode
	// ****************************************
	reg  [1:0]  div_r;
	reg  [TW-1:0] width;
	reg         inc_c;
	reg         inc_d;
	reg         rel;
	reg  [1:0]  src_c;
	reg  [1:0]  src_d;
	wire        div_tick = p_rise && div_r == `MPOC_DIV_FACTOR;
	wire        mode_cnt = func_r == `MPOC_FC_CNT_10 || func_r == `MPOC_FC_CNT_32 ||
		func_r == `MPOC_FC_CNT_100;
	wire        mode_cmd = func_r == `MPOC_FC_CMD;
	reg  [7:0]  func_d_r;
	wire        mode_chg = func_d_r != func_r;

	// Divide-by-four counter for primary flow pulses.
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			div_r    <= 2'h0;
			func_d_r <= `MPOC_FC_RESET;
		end else begin
			func_d_r <= func_r;
			if (p_rise) begin
				div_r <= div_r + 2'h1;
			end
		end
	end

	// Sources fixed by meter type parameter only.
	always @* begin
		case (METER_TYPE)
			4'h3, 4'h6: begin
				src_c = `MPOC_SRC_HEAT;
				src_d = `MPOC_SRC_COOL;
			end
			4'h5: begin
				src_c = `MPOC_SRC_COOL;
				src_d = `MPOC_SRC_VOL;
			end
			4'h7: begin
				src_c = `MPOC_SRC_VOL;
				src_d = `MPOC_SRC_VOL;
			end
			default: begin
				src_c = `MPOC_SRC_HEAT;
				src_d = `MPOC_SRC_VOL;
			end
		endcase
	end

	// Per-mode width, events and release policy.
	always @* begin
		width = CYC95;
		inc_c = 1'b0;
		inc_d = 1'b0;
		rel   = 1'b1;
		case (func_r)
			`MPOC_FC_DIV4_5: begin
				width = CYC73;
				inc_c = div_tick;
			end
			`MPOC_FC_DIV4_22: begin
				width = CYC83;
				inc_c = div_tick;
			end
			`MPOC_FC_BOTH_1: begin
				width = CYC80;
				inc_c = p_rise;
				inc_d = s_rise;
			end
			`MPOC_FC_C_1: begin
				width = CYC80;
				inc_c = p_rise;
			end
			`MPOC_FC_CNT_10, `MPOC_FC_CNT_32, `MPOC_FC_CNT_100: begin
				width = (func_r == `MPOC_FC_CNT_10) ? CYC94 :
					(func_r == `MPOC_FC_CNT_100) ? CYC96 : CYC95;
				// Each increment is one least-digit unit of its register.
				inc_c = (src_c == `MPOC_SRC_HEAT) ? heat_energy_total_inc_i :
					(src_c == `MPOC_SRC_COOL) ? cooling_energy_total_inc_i :
					volume_pulse_channel_inc_i;
				inc_d = (src_d == `MPOC_SRC_COOL) ? cooling_energy_total_inc_i :
					volume_pulse_channel_inc_i;
				rel   = integration_tick_i;
			end
			default: begin
				width = CYC95;
			end
		endcase
	end

	// ****************************************
	// Channel C and D generators
	// ****************************************
	mpoc_pulse_gen #(.CW(CW), .TW(TW)) u_gen_c (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.inc_i      (inc_c),
		.release_i  (rel),
		.clear_i    (mode_chg || mode_cmd),
		.width_i    (width),
		.active_o   (act_c),
		.pend_o     (pend_c)
	);

	mpoc_pulse_gen #(.CW(CW), .TW(TW)) u_gen_d (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.inc_i      (inc_d),
		.release_i  (rel),
		.clear_i    (mode_chg || mode_cmd),
		.width_i    (width),
		.active_o   (act_d),
		.pend_o     (pend_d)
	);

	// Pair outputs: closed when high; slots share one drive.
	wire drive_c = mode_cmd ? cmd_r[0] : act_c;
	wire drive_d = mode_cmd ? cmd_r[1] : act_d;
	assign out_c1_o = drive_c;
	assign out_c2_o = drive_c;
	assign out_d1_o = drive_d;
	assign out_d2_o = drive_d;
endmodule // mpoc_top

// ==== test/mpoc_counter.sv ====
// Purpose: Far-side counter that watches the output pins.
// Assumes: Pins are sampled on the core clock.
// Notes:   Counts slot-one closures and latches any slot disagreement.
`timescale 1ns/1ps
module mpoc_counter (
	// Clock.
	input  wire        core_clk_i,
	// Output pins.
	input  wire        c1_i,
	input  wire        c2_i,
	input  wire        d1_i,
	input  wire        d2_i,
	// Counts and flags.
	output reg  [31:0] cnt_c_o = 32'h0,
	output reg  [31:0] cnt_d_o = 32'h0,
	output reg         split_o = 1'b0
);
	reg c_r = 1'b0;
	reg d_r = 1'b0;
	// ****************
	// Closure counting
	// ****************
	// A closure is counted on its rising edge; the two slots must agree.
	always @(posedge core_clk_i) begin
		c_r <= c1_i;
		d_r <= d1_i;
		if (c1_i === 1'b1 && c_r === 1'b0) cnt_c_o <= cnt_c_o + 32'h1;
		if (d1_i === 1'b1 && d_r === 1'b0) cnt_d_o <= cnt_d_o + 32'h1;
		split_o <= split_o | (c1_i !== c2_i) | (d1_i !== d2_i);
	end
endmodule // mpoc_counter

// ==== test/mpoc_chk.sv ====
// Purpose: Port assertions for the pulse output control block.
// Assumes: One core clock and a synchronous active-high reset.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/1ps
module mpoc_chk #(
	parameter       CW         = 16,
	parameter [3:0] METER_TYPE = 4'h1
) (
	// Clock and reset.
	input wire        core_clk_i,
	input wire        rst_i,
	// Register bus.
	input wire        avs_read_i,
	input wire        avs_write_i,
	input wire [31:0] avs_readdata_o,
	input wire        avs_waitrequest_o,
	// Outputs.
	input wire        nvm_save_o,
	input wire        out_c1_o,
	input wire        out_c2_o,
	input wire        out_d1_o,
	input wire        out_d2_o
);
	// ****************
	// Properties
	// ****************
	// All checks share the core clock and rest during reset.
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	a_pair_c_same: assert property (out_c1_o == out_c2_o)
		else $error("C slot outputs differ");
	a_pair_d_same: assert property (out_d1_o == out_d2_o)
		else $error("D slot outputs differ");
	a_reset_open: assert property ($fell(rst_i) |-> !out_c1_o && !out_d1_o)
		else $error("output closed after reset");
	a_gap_c_open: assert property ($fell(out_c1_o) |-> !out_c1_o [*8])
		else $error("C closed again too soon");
	a_wait_first: assert property (($rose(avs_read_i) || $rose(avs_write_i)) |->
		avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("wait request timing wrong");
	a_wait_idle: assert property (!avs_read_i && !avs_write_i |-> !avs_waitrequest_o)
		else $error("wait request without request");
	a_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data changed without read");
	a_save_once: assert property (nvm_save_o |=> !nvm_save_o)
		else $error("save pulse too long");
	a_save_cause: assert property (nvm_save_o |-> $past(avs_write_i) || $past(avs_write_i, 2))
		else $error("save without a write");
	// Main scenarios reached.
	cover property ($rose(out_c1_o));
	cover property ($rose(out_d1_o));
	cover property (nvm_save_o);
endmodule // mpoc_chk

bind mpoc_top mpoc_chk #(.CW(CW), .METER_TYPE(METER_TYPE)) u_mpoc_chk (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .nvm_save_o(nvm_save_o),
	.out_c1_o(out_c1_o), .out_c2_o(out_c2_o), .out_d1_o(out_d1_o), .out_d2_o(out_d2_o)
);

// ==== test/test_meter_pulse_output_control.sv ====
// Purpose: Self-checking bench for the pulse output control block.
// Assumes: Full-length widths, so pulses are seen starting, not ending.
// Notes:   Mode writes cut active pulses short between scenarios.
`timescale 1ns/1ps
`include "mpoc_defines.vh"
module test_meter_pulse_output_control;
	reg         core_clk_i = 1'b0;
	reg         rst_i      = 1'b1;
	reg  [3:0]  adr        = 4'h0;
	reg         rd         = 1'b0;
	reg         wr         = 1'b0;
	reg  [31:0] wd         = 32'h0;
	reg         pf         = 1'b0;
	reg         sf         = 1'b0;
	reg  [3:0]  evt        = 4'h0;
	reg  [1:0]  nv         = 2'h0;
	reg  [31:0] q;
	reg  [31:0] pc;
	wire [31:0] rdata;
	wire        wreq;
	wire        save;
	wire [1:0]  nvo;
	wire [3:0]  outs;
	wire [31:0] cc;
	wire [31:0] cd;
	wire        split;
	integer     mismatches = 0;
	integer     checks     = 0;
	integer     cyc        = 0;
	integer     i;
	// Clock, and a cycle ceiling that cuts a hang short.
	always #12.5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			test_done;
		end
	end
	// ****************
	// Block and far side
	// ****************
	mpoc_top u_mpoc_top (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.primary_flow_volume_i(pf), .secondary_flow_volume_i(sf),
		.heat_energy_total_inc_i(evt[0]), .cooling_energy_total_inc_i(evt[1]),
		.volume_pulse_channel_inc_i(evt[2]), .integration_tick_i(evt[3]),
		.display_resolution_code_i(10'h077), .nvm_cmd_state_i(nv), .nvm_save_o(save),
		.nvm_cmd_state_o(nvo), .out_c1_o(outs[0]), .out_c2_o(outs[1]),
		.out_d1_o(outs[2]), .out_d2_o(outs[3])
	);
	mpoc_counter u_mpoc_counter (
		.core_clk_i(core_clk_i), .c1_i(outs[0]), .c2_i(outs[1]), .d1_i(outs[2]),
		.d2_i(outs[3]), .cnt_c_o(cc), .cnt_d_o(cd), .split_o(split)
	);
	// ****************
	// Shared tasks
	// ****************
	// Compares one value and counts the outcome.
	task check(input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// One bus access, held until wait request is seen low at an edge.
	task bus(input w, input [1:0] r, input [31:0] d);
		begin
			@(posedge core_clk_i);
			adr <= {r, 2'b00};
			wr <= w;
			rd <= !w;
			wd <= d;
			@(posedge core_clk_i);
			while (wreq !== 1'b0) @(posedge core_clk_i);
			q = rdata;
			wr <= 1'b0;
			rd <= 1'b0;
		end
	endtask
	// A flow pin pulse, primary or secondary, with idle time around it.
	task pin(input s);
		begin
			repeat (4) @(posedge core_clk_i);
			if (s) sf <= 1'b1;
			else pf <= 1'b1;
			repeat (4) @(posedge core_clk_i);
			pf <= 1'b0;
			sf <= 1'b0;
			repeat (4) @(posedge core_clk_i);
		end
	endtask
	// One-cycle event pulses: bit 0 heat, 1 cooling, 2 volume, 3 tick.
	task ev(input [3:0] m);
		begin
			@(posedge core_clk_i);
			evt <= m;
			@(posedge core_clk_i);
			evt <= 4'h0;
		end
	endtask
	// Waits and settles to the falling edge before sampling.
	task wt(input integer n);
		begin
			repeat (n) @(posedge core_clk_i);
			@(negedge core_clk_i);
		end
	endtask
	// ****************
	// Scenarios
	// ****************
	// Reset state of the mode and the outputs.
	task t_reset;
		begin
			bus(1'b0, `MPOC_REG_FUNC, 32'h0);
			check(q, 32'h5F);
			check(outs, 32'h0);
			$display("reset test done");
		end
	endtask
	// Commanded mode: pairs switched separately, state saved and readable.
	task t_cmd;
		begin
			bus(1'b1, `MPOC_REG_FUNC, `MPOC_FC_CMD);
			bus(1'b1, `MPOC_REG_CMD, 32'h1);
			wt(10);
			check(outs, 32'h3);
			check(nvo, 32'h1);
			bus(1'b0, `MPOC_REG_CMD, 32'h0);
			check(q, 32'h1);
			bus(1'b0, `MPOC_REG_STAT, 32'h0);
			check(q, 32'h0000_01DD);
			bus(1'b1, `MPOC_REG_CMD, 32'h2);
			wt(10);
			check(outs, 32'hC);
			bus(1'b1, `MPOC_REG_CMD, 32'h0);
			wt(10);
			check(outs, 32'h0);
			$display("command test done");
		end
	endtask
	// Stored state comes back after a reset in mid-run.
	task t_nvm;
		begin
			@(posedge core_clk_i);
			rst_i <= 1'b1;
			nv <= 2'h3;
			repeat (3) @(posedge core_clk_i);
			rst_i <= 1'b0;
			wt(3);
			check(outs, 32'h0);
			bus(1'b1, `MPOC_REG_FUNC, `MPOC_FC_CMD);
			wt(4);
			check(outs, 32'hF);
			nv <= 2'h0;
			$display("restore test done");
		end
	endtask
	// Divider: three primary pulses give nothing, the fourth closes C only.
	task t_div(input [7:0] code);
		begin
			bus(1'b1, `MPOC_REG_FUNC, code);
			repeat (3) pin(1'b0);
			wt(8);
			check(outs, 32'h0);
			pin(1'b0);
			wt(4);
			check(outs, 32'h3);
			$display("divider test done");
		end
	endtask
	// Transmitter modes: both channels, then primary only.
	task t_rep;
		begin
			bus(1'b1, `MPOC_REG_FUNC, `MPOC_FC_BOTH_1);
			pin(1'b0);
			wt(4);
			check(outs, 32'h3);
			pin(1'b1);
			wt(4);
			check(outs, 32'hF);
			bus(1'b1, `MPOC_REG_FUNC, `MPOC_FC_C_1);
			pin(1'b1);
			wt(4);
			check(outs, 32'h0);
			pin(1'b0);
			wt(4);
			check(outs, 32'h3);
			$display("transmitter test done");
		end
	endtask
	// Count mode: heat to C, volume to D, cooling unused, sent at the tick.
	task t_cnt(input [7:0] code);
		begin
			bus(1'b1, `MPOC_REG_FUNC, code);
			ev(4'h1);
			ev(4'h1);
			ev(4'h4);
			ev(4'h2);
			bus(1'b0, `MPOC_REG_PEND, 32'h0);
			check(q, 32'h0001_0002);
			check(outs, 32'h0);
			pc = cc;
			ev(4'h8);
			wt(6);
			check(outs, 32'hF);
			check(cc - pc, 32'h1);
			check(split, 32'h0);
			$display("count test done");
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task test_done;
		begin
			$display("checks %0d mismatches %0d", checks, mismatches);
			if (mismatches == 0 && checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Main sequence after a three-cycle reset.
	initial begin
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_cmd;
		t_nvm;
		t_div(`MPOC_FC_DIV4_5);
		t_div(`MPOC_FC_DIV4_22);
		t_rep;
		for (i = 0; i < 3; i = i + 1) t_cnt(`MPOC_FC_CNT_10 + i);
		test_done;
	end
endmodule // test_meter_pulse_output_control
